/* fsdb_diag_builder.sv */
// Fieldbus slave diagnostic record builder with APB registers
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fsdb_diag_builder (
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clk_en_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [7:0]  st0_flags_in,
    input  wire logic [7:0]  st1_flags_in,
    input  wire logic [7:0]  master_addr_in,
    input  wire logic [15:0] ident_in,
    input  wire logic        err_valid_in,
    input  wire logic [7:0]  err_code_in,
    input  wire logic        diag_req_in,
    input  wire logic        tx_ready_in,
    output logic             tx_valid_out,
    output logic [7:0]       tx_byte_out,
    output logic             tx_last_out,
    output logic [7:0]       img_base_out,
    output logic             diag_active_out
);
    localparam int IDXW = $clog2(fsdb_pkg::REC_LEN);

    function automatic logic bad_status(input logic [7:0] v);
        bad_status = (v & fsdb_pkg::ST_MASK) == fsdb_pkg::ST_MASK;
    endfunction

    logic [7:0]   status_q, status_d;
    logic [39:0]  user_q, user_d;
    logic [7:0]   base_q, base_d;
    logic [7:0]   msg_q, msg_d;
    logic         active_q, active_d;
    logic         ovf_q, ovf_d;
    logic         pend_q, pend_d;
    logic [127:0] frame_q, frame_d;
    logic [IDXW-1:0] idx_q, idx_d;
    fsdb_pkg::fsdb_tx_state_type state_q, state_d;

    logic         wr_status, wr_user0, wr_user1, wr_ctrl;
    logic [127:0] record;
    logic [7:0]   new_status;
    logic         start_diag, del_diag, err_hit, is_last;

    fsdb_apb u_apb (
        .psel_in       (psel_in),
        .penable_in    (penable_in),
        .pwrite_in     (pwrite_in),
        .paddr_in      (paddr_in),
        .rd_status_in  (status_q),
        .rd_user_in    (user_q),
        .rd_ctrl_in    ({msg_q, base_q}),
        .rd_state_in   ({4'h0, ovf_q, pend_q,
                         state_q == fsdb_pkg::TX_SEND, active_q}),
        .wr_status_out (wr_status),
        .wr_user0_out  (wr_user0),
        .wr_user1_out  (wr_user1),
        .wr_ctrl_out   (wr_ctrl),
        .prdata_out    (prdata_out),
        .pslverr_out   (pslverr_out)
    );

    fsdb_record u_rec (
        .st0_in         (st0_flags_in),
        .st1_in         (st1_flags_in),
        .overflow_in    (ovf_q),
        .master_addr_in (master_addr_in),
        .ident_in       (ident_in),
        .msg_code_in    (msg_q),
        .user_in        (user_q),
        .record_out     (record)
    );

    assign pready_out      = 1'b1;
    assign img_base_out    = base_q;
    assign diag_active_out = active_q;

    // Register writes and diagnostic release
    always_comb begin
        new_status = status_q;
        user_d     = user_q;
        base_d     = base_q;
        if (wr_status) begin
            new_status = pwdata_in[7:0] & fsdb_pkg::ST_MASK;
        end
        if (wr_user0) begin
            user_d[31:0] = pwdata_in;
        end
        if (wr_user1) begin
            user_d[39:32] = pwdata_in[7:0];
        end
        if (wr_ctrl) begin
            base_d = pwdata_in[7:0];
        end
        start_diag = wr_status && !bad_status(new_status)
                     && new_status[fsdb_pkg::ST_VALID_BIT]
                     && !status_q[fsdb_pkg::ST_VALID_BIT];
        del_diag   = wr_status && !bad_status(new_status)
                     && new_status[fsdb_pkg::ST_DELETE_BIT];
        status_d   = bad_status(new_status) ? status_q : new_status;
        err_hit    = err_valid_in
                     && err_code_in >= fsdb_pkg::MSG_ERR_FIRST
                     && err_code_in <= fsdb_pkg::MSG_ERR_LAST;
        active_d   = active_q;
        msg_d      = msg_q;
        if (del_diag) begin
            active_d = 1'b0;
            msg_d    = fsdb_pkg::MSG_NONE;
        end
        if (start_diag) begin
            active_d = 1'b1;
            msg_d    = fsdb_pkg::MSG_USER_VALID;
        end
        if (err_hit) begin
            msg_d = err_code_in;
        end
    end

    // Transmit sequencer
    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        frame_d = frame_q;
        pend_d  = pend_q | diag_req_in | start_diag | err_hit;
        ovf_d   = ovf_q;
        is_last = idx_q == IDXW'(fsdb_pkg::REC_LEN - 1);
        if (state_q == fsdb_pkg::TX_SEND && (diag_req_in || err_hit)) begin
            ovf_d = 1'b1;
        end
        unique case (state_q)
            fsdb_pkg::TX_IDLE: begin
                if (pend_q) begin
                    frame_d = record;
                    ovf_d   = 1'b0;
                    idx_d   = '0;
                    pend_d  = diag_req_in | start_diag | err_hit;
                    state_d = fsdb_pkg::TX_SEND;
                end
            end
            fsdb_pkg::TX_SEND: begin
                if (tx_ready_in) begin
                    frame_d = {8'h00, frame_q[127:8]};
                    idx_d   = idx_q + 1'b1;
                    if (is_last) begin
                        idx_d   = '0;
                        state_d = fsdb_pkg::TX_IDLE;
                    end
                end
            end
        endcase
        tx_valid_out = state_q == fsdb_pkg::TX_SEND;
        tx_last_out  = tx_valid_out && is_last;
        tx_byte_out  = frame_q[7:0];
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            status_q <= 8'h00;
            user_q   <= '0;
            base_q   <= fsdb_pkg::IMG_BASE_RST;
            msg_q    <= fsdb_pkg::MSG_NONE;
            active_q <= 1'b0;
            ovf_q    <= 1'b0;
            pend_q   <= 1'b0;
            frame_q  <= '0;
            idx_q    <= '0;
            state_q  <= fsdb_pkg::TX_IDLE;
        end else if (clk_en_in) begin
            status_q <= status_d;
            user_q   <= user_d;
            base_q   <= base_d;
            msg_q    <= msg_d;
            active_q <= active_d;
            ovf_q    <= ovf_d;
            pend_q   <= pend_d;
            frame_q  <= frame_d;
            idx_q    <= idx_d;
            state_q  <= state_d;
        end
    end
endmodule
`default_nettype wire

/* fsdb_pkg.sv */
// Package of constants for the fieldbus slave diagnostic record builder
package fsdb_pkg;
    localparam int          REC_LEN        = 16;
    localparam logic [7:0]  OFS_STATUS     = 8'h00;
    localparam logic [7:0]  OFS_USER0      = 8'h04;
    localparam logic [7:0]  OFS_USER1      = 8'h08;
    localparam logic [7:0]  OFS_CTRL       = 8'h0c;
    localparam logic [7:0]  OFS_STATE      = 8'h10;
    localparam int          ST_VALID_BIT   = 0;
    localparam int          ST_DELETE_BIT  = 1;
    localparam logic [7:0]  ST_MASK        = 8'h03;
    localparam logic [7:0]  ST0_MASK       = 8'h5e;
    localparam logic [7:0]  ST1_MASK       = 8'h3b;
    localparam logic [7:0]  ST1_FIXED_ONE  = 8'h04;
    localparam logic [7:0]  ST2_MASK       = 8'h80;
    localparam logic [7:0]  DEV_LEN_CODE   = 8'h0a;
    localparam logic [7:0]  MSG_USER_VALID = 8'h40;
    localparam logic [7:0]  MSG_ERR_FIRST  = 8'h12;
    localparam logic [7:0]  MSG_ERR_LAST   = 8'h17;
    localparam logic [7:0]  MSG_NONE       = 8'h00;
    localparam int          USER_FIRST     = 11;
    localparam int          USER_BYTES     = 5;
    localparam logic [7:0]  IMG_BASE_RST   = 8'h00;
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_SEND
    } fsdb_tx_state_type;
endpackage

/* fsdb_apb.sv */
// APB slave register decoder and read mux
`timescale 1ns/1ps
`default_nettype none
module fsdb_apb (
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [7:0]  rd_status_in,
    input  wire logic [39:0] rd_user_in,
    input  wire logic [15:0] rd_ctrl_in,
    input  wire logic [7:0]  rd_state_in,
    output logic             wr_status_out,
    output logic             wr_user0_out,
    output logic             wr_user1_out,
    output logic             wr_ctrl_out,
    output logic [31:0]      prdata_out,
    output logic             pslverr_out
);
    logic access;
    logic hit;
    always_comb begin
        access        = psel_in & penable_in;
        wr_status_out = 1'b0;
        wr_user0_out  = 1'b0;
        wr_user1_out  = 1'b0;
        wr_ctrl_out   = 1'b0;
        prdata_out    = 32'h0000_0000;
        hit           = 1'b1;
        unique case (paddr_in)
            fsdb_pkg::OFS_STATUS: begin
                wr_status_out = access & pwrite_in;
                prdata_out    = {24'h00_0000, rd_status_in};
            end
            fsdb_pkg::OFS_USER0: begin
                wr_user0_out = access & pwrite_in;
                prdata_out   = rd_user_in[31:0];
            end
            fsdb_pkg::OFS_USER1: begin
                wr_user1_out = access & pwrite_in;
                prdata_out   = {24'h00_0000, rd_user_in[39:32]};
            end
            fsdb_pkg::OFS_CTRL: begin
                wr_ctrl_out = access & pwrite_in;
                prdata_out  = {16'h0000, rd_ctrl_in};
            end
            fsdb_pkg::OFS_STATE: begin
                prdata_out = {24'h00_0000, rd_state_in};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        pslverr_out = access & ~hit;
    end
endmodule
`default_nettype wire

/* fsdb_record.sv */
// Combinational assembly of the sixteen-byte diagnostic record
`timescale 1ns/1ps
`default_nettype none
module fsdb_record (
    input  wire logic [7:0]   st0_in,
    input  wire logic [7:0]   st1_in,
    input  wire logic         overflow_in,
    input  wire logic [7:0]   master_addr_in,
    input  wire logic [15:0]  ident_in,
    input  wire logic [7:0]   msg_code_in,
    input  wire logic [39:0]  user_in,
    output logic [127:0]      record_out
);
    always_comb begin
        record_out          = '0;
        record_out[7:0]     = st0_in & fsdb_pkg::ST0_MASK;
        record_out[15:8]    = (st1_in & fsdb_pkg::ST1_MASK)
                              | fsdb_pkg::ST1_FIXED_ONE;
        record_out[23:16]   = {overflow_in, 7'h00};
        record_out[31:24]   = master_addr_in;
        record_out[39:32]   = ident_in[15:8];
        record_out[47:40]   = ident_in[7:0];
        record_out[55:48]   = fsdb_pkg::DEV_LEN_CODE;
        record_out[63:56]   = msg_code_in;
        record_out[127:88]  = user_in;
    end
endmodule
`default_nettype wire

/* fsdb_master_model.sv */
// Diagnostic collecting master model with optional stalls
`timescale 1ns/1ps
`default_nettype none
module fsdb_master_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       slow_in,
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       tx_last_in,
    output logic            tx_ready_out,
    output logic [127:0]    rec_out,
    output logic            done_out,
    output logic [3:0]      cnt_out
);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_ready_out <= 1'b0;
            rec_out <= '0;
            done_out <= 1'b0;
            cnt_out <= 4'h0;
        end else begin
            tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
            done_out <= 1'b0;
            if (tx_valid_in && tx_ready_out) begin
                rec_out[{cnt_out, 3'b000} +: 8] <= tx_byte_in;
                cnt_out <= tx_last_in ? 4'h0 : cnt_out + 4'h1;
                done_out <= tx_last_in;
            end
        end
    end
endmodule
`default_nettype wire

/* fsdb_diag_builder_props.sv */
// Port checker of the diagnostic record builder
`timescale 1ns/1ps
`default_nettype none
module fsdb_diag_builder_props (
    input wire logic        ref_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [7:0]  st0_flags_in,
    input wire logic [15:0] ident_in,
    input wire logic        diag_req_in,
    input wire logic        tx_ready_in,
    input wire logic        tx_valid_out,
    input wire logic [7:0]  tx_byte_out,
    input wire logic        tx_last_out,
    input wire logic        diag_active_out
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Index of the byte on offer
    always_comb begin
        cnt_d = cnt_q;
        if (tx_valid_out && tx_ready_in) begin
            cnt_d = tx_last_out ? 4'h0 : cnt_q + 4'h1;
        end
    end
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    sequence s_wr(logic [1:0] v);
        psel_in && penable_in && pwrite_in && paddr_in == 8'h00
            && pwdata_in[1:0] == v;
    endsequence
    sequence s_byte(int k);
        tx_valid_out && cnt_q == k;
    endsequence
    a_req_sends: assert property (diag_req_in |-> ##[1:80] tx_valid_out)
        else $error("no record after request");
    a_byte_held: assert property (tx_valid_out && !tx_ready_in
        |=> tx_valid_out && $stable(tx_byte_out)) else $error("byte dropped");
    a_last_at15: assert property (tx_valid_out
        |-> tx_last_out == (cnt_q == 4'hf)) else $error("last misplaced");
    a_st0_bits: assert property (s_byte(0)
        |-> tx_byte_out == (st0_flags_in & 8'h5e)) else $error("byte 0 bad");
    a_ident_high: assert property (s_byte(4)
        |-> tx_byte_out == ident_in[15:8]) else $error("ident order bad");
    a_len_code: assert property (s_byte(6) |-> tx_byte_out == 8'h0a)
        else $error("length byte bad");
    a_start_sets: assert property (s_wr(2'b01) ##0 !diag_active_out
        |=> diag_active_out) else $error("start lost");
    a_ignore_both: assert property (s_wr(2'b11)
        |=> $stable(diag_active_out)) else $error("both bits acted");
    a_delete_clr: assert property (s_wr(2'b10) |=> !diag_active_out)
        else $error("delete lost");
endmodule
bind fsdb_diag_builder fsdb_diag_builder_props u_props (
    .ref_clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .st0_flags_in, .ident_in, .diag_req_in,
    .tx_ready_in, .tx_valid_out, .tx_byte_out, .tx_last_out,
    .diag_active_out);
`default_nettype wire

/* testbench.sv */
// Self-checking bench of the diagnostic record builder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic         clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
    logic         req = 0, err = 0, slow = 0, ce = 1, pe, rdy, perr;
    logic         txv, txr, txl, act, done;
    logic [7:0]   pad = 0, ec = 0, st0 = 0, st1 = 0, mad = 0, txb, ib;
    logic [15:0]  idn = 0;
    logic [31:0]  pwd = 0, prd, r, u0, u1, v, seed = 32'h2c75;
    logic [127:0] rec;
    logic [127:0] q[$];
    logic [3:0]   cnt;
    int           failures = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    fsdb_diag_builder u_dut (.ref_clk_in(clk), .sys_rst_in(rst),
        .clk_en_in(ce), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(perr), .st0_flags_in(st0),
        .st1_flags_in(st1), .master_addr_in(mad), .ident_in(idn),
        .err_valid_in(err), .err_code_in(ec), .diag_req_in(req),
        .tx_ready_in(txr), .tx_valid_out(txv), .tx_byte_out(txb),
        .tx_last_out(txl), .img_base_out(ib), .diag_active_out(act));
    fsdb_master_model u_mst (.clk_in(clk), .rst_in(rst), .slow_in(slow),
        .tx_valid_in(txv), .tx_byte_in(txb), .tx_last_in(txl),
        .tx_ready_out(txr), .rec_out(rec), .done_out(done), .cnt_out(cnt));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [127:0] exp_rec(logic [7:0] m, logic ov);
        return {u1[7:0], u0, 24'h0, m, 8'h0a, idn[7:0], idn[15:8], mad,
            ov, 7'h0, (st1 & 8'h3b) | 8'h04, st0 & 8'h5e};
    endfunction
    task automatic check(logic [127:0] seen, logic [127:0] ex, string nm);
        n_checks++;
        if (seen !== ex) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        r = prd;
        pe = perr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task automatic pulse(logic e, logic [7:0] c);
        err <= e;
        req <= !e;
        ec <= c;
        @(posedge clk);
        err <= 0;
        req <= 0;
        @(posedge clk);
    endtask
    task automatic quiet();
        repeat (6) @(posedge clk);
        check(txv, 0, "quiet");
    endtask
    task automatic drain();
        while (q.size() != 0) @(posedge clk);
    endtask
    task automatic summarize();
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (done) check(rec, q.size() ? q.pop_front() : 'x, "record");
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        apb(0, 8'h00, 0);
        check(r, 0, "status");
        apb(0, 8'h40, 0);
        check(pe, 1, "unmapped");
        r = xs();
        st0 <= r[7:0];
        st1 <= r[15:8];
        mad <= r[23:16];
        idn <= r[31:16];
        u0 = xs();
        u1 = xs();
        apb(1, 8'h04, u0);
        apb(1, 8'h08, u1);
        q.push_back(exp_rec(8'h40, 0));
        apb(1, 8'h00, 1);
        drain();
        check(act, 1, "active");
        apb(1, 8'h00, 3);
        apb(0, 8'h00, 0);
        check(r, 1, "ignored");
        apb(1, 8'h00, 1);
        quiet();
        slow <= 1;
        q.push_back(exp_rec(8'h40, 0));
        pulse(0, 0);
        while (cnt < 4) @(posedge clk);
        q.push_back(exp_rec(8'h40, 1));
        pulse(0, 0);
        drain();
        slow <= 0;
        apb(1, 8'h00, 2);
        check(act, 0, "deleted");
        q.push_back(exp_rec(0, 0));
        pulse(0, 0);
        drain();
        for (int c = 8'h12; c <= 8'h17; c++) begin
            q.push_back(exp_rec(8'(c), 0));
            pulse(1, 8'(c));
            drain();
        end
        pulse(1, 8'h18);
        quiet();
        v = xs();
        apb(1, 8'h0c, v);
        check(ib, v[7:0], "image base");
        ce <= 0;
        apb(1, 8'h0c, ~v);
        ce <= 1;
        apb(0, 8'h0c, 0);
        check(r, {16'h0, 8'h17, v[7:0]}, "control");
        apb(0, 8'h04, 0);
        check(r, u0, "user low");
        apb(0, 8'h10, 0);
        check(r, 0, "state");
        summarize();
    end
endmodule
`default_nettype wire
